// *** dv/port_master.sv ***
module port_master #(
    parameter int HALF = 4
) (
    // System.
    input wire logic clk,
    // Port pins.
    output flag_pkg::port_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        pins = '0;
    end

    // One port clock period with the request levels held around the rising edge.
    // Once the hold has run out the request lines show the inverse of their last value.
    task automatic pulse(input logic w, input logic r);
        @(posedge clk);
        pins.wr <= w;
        pins.rd <= r;
        repeat (HALF) @(posedge clk);
        pins.clk <= 1'b1;
        repeat (HALF) @(posedge clk);
        pins.clk <= 1'b0;
        pins.wr <= ~w;
        pins.rd <= ~r;
        repeat (2) @(posedge clk);
    endtask
endmodule

// *** dv/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DEPTH = 16;

    typedef struct packed {
        logic [31:0] d;
        logic e;
        logic i;
        logic p;
    } note_t;

    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, serial_enable, serial_bit;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    flag_pkg::port_pins_t porta_pins, portb_pins;
    logic porta_empty_or_outready, porta_almost_empty, porta_almost_full, porta_full_or_inready;
    logic portb_empty_or_outready, portb_almost_empty, portb_almost_full, portb_full_or_inready;
    note_t notes[$];
    note_t n;
    int mismatches, checks_done;
    int w[2], r[2], xo[2], yo[2];
    logic [3:0] st_m, en_m;

    ////////////////////////////////////////////////////////////////////////////////

    always #25 clk = ~clk;

    bidir_fifo_status_flags #(.AW(4)) i_bidir_fifo_status_flags (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porta_pins(porta_pins), .portb_pins(portb_pins),
        .serial_enable(serial_enable), .serial_bit(serial_bit),
        .porta_empty_or_outready(porta_empty_or_outready), .porta_almost_empty(porta_almost_empty),
        .porta_almost_full(porta_almost_full), .porta_full_or_inready(porta_full_or_inready),
        .portb_empty_or_outready(portb_empty_or_outready), .portb_almost_empty(portb_almost_empty),
        .portb_almost_full(portb_almost_full), .portb_full_or_inready(portb_full_or_inready),
        .irq(irq));

    port_master #(.HALF(4)) i_port_a (.clk(clk), .pins(porta_pins));
    port_master #(.HALF(5)) i_port_b (.clk(clk), .pins(portb_pins));

    ////////////////////////////////////////////////////////////////////////////////

    task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic compare_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // The monitor takes the oldest note at every completed read.
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (notes.size() == 0)
                compare_bit(1'b1, 1'b0);
            else
            begin
                n = notes.pop_front();
                compare_word(prdata, n.d);
                compare_bit(pslverr, n.e);
                compare_bit(irq, n.i);
                if (n.p)
                    compare_word({24'h000000, porta_empty_or_outready, porta_almost_empty, porta_almost_full,
                        porta_full_or_inready, portb_empty_or_outready, portb_almost_empty, portb_almost_full,
                        portb_full_or_inready}, n.d);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        if (pready !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic err, input logic p);
        notes.push_back('{e, err, |(st_m & en_m), p});
        apb(1'b0, a, 32'h00000000);
    endtask

    task automatic op(input int p, input logic wv, input logic rv);
        if (p == 0)
            i_port_a.pulse(wv, rv);
        else
            i_port_b.pulse(wv, rv);
    endtask

    function automatic logic [7:0] flags();
        return {r[1] > 0, r[1] > xo[1], w[0] < DEPTH - yo[0], w[0] != DEPTH,
            r[0] > 0, r[0] > xo[0], w[1] < DEPTH - yo[1], w[1] != DEPTH};
    endfunction

    task automatic chk(input logic [7:0] fx);
        rd_reg(flag_pkg::ADDR_FLAGS, {24'h000000, fx}, 1'b0, 1'b1);
        rd_reg(flag_pkg::ADDR_COUNTS, 32'((w[1] << 16) | w[0]), 1'b0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial
    begin
        logic [7:0] offs[4];
        logic [3:0] sb;
        offs = '{flag_pkg::ADDR_Q1_EMPTY_OFF, flag_pkg::ADDR_Q1_FULL_OFF,
            flag_pkg::ADDR_Q2_EMPTY_OFF, flag_pkg::ADDR_Q2_FULL_OFF};
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, serial_enable, serial_bit} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        st_m = 4'h0;
        en_m = 4'h0;
        w = '{0, 0};
        r = '{0, 0};
        void'($urandom(50928));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd_reg(flag_pkg::ADDR_CTRL, 32'h00000000, 1'b0, 1'b0);
        rd_reg(flag_pkg::ADDR_FLAGS, 32'h00000033, 1'b0, 1'b1);
        rd_reg(flag_pkg::ADDR_IRQ_ENABLE, 32'h00000000, 1'b0, 1'b0);
        rd_reg(flag_pkg::ADDR_IRQ_CLEAR, 32'h00000000, 1'b0, 1'b0);
        rd_reg(8'h28, 32'h00000000, 1'b1, 1'b0);
        foreach (offs[k])
            rd_reg(offs[k], flag_pkg::OFFSET_PRESET, 1'b0, 1'b0);
        xo = '{$urandom_range(4, 1), 2};
        yo = '{3, 1};
        foreach (offs[k])
        begin
            apb(1'b1, offs[k], (k % 2) ? yo[k / 2] : xo[k / 2]);
            rd_reg(offs[k], (k % 2) ? yo[k / 2] : xo[k / 2], 1'b0, 1'b0);
        end
        en_m = 4'hF;
        apb(1'b1, flag_pkg::ADDR_IRQ_ENABLE, 32'h0000000F);
        // Queue q is written by port q and read by the other port.
        for (int q = 0; q < 2; q++)
        begin
            for (int i = 1; i <= DEPTH + 1; i++)
            begin
                op(q, 1'b1, 1'b0);
                if (i > DEPTH)
                    st_m[2 * q] = 1'b1;
                else
                    w[q]++;
                op(1 - q, 1'b0, 1'b0);
                if (i == 1)
                    chk(flags());
                op(1 - q, 1'b0, 1'b0);
                r[q] = w[q];
                chk(flags());
            end
            for (int i = 1; i <= DEPTH + 1; i++)
            begin
                op(1 - q, 1'b0, 1'b1);
                if (i > DEPTH)
                    st_m[2 * q + 1] = 1'b1;
                else
                    r[q]--;
                op(q, 1'b0, 1'b0);
                if (i == 1)
                    chk(flags());
                op(q, 1'b0, 1'b0);
                w[q] = r[q];
                chk(flags());
            end
            rd_reg(flag_pkg::ADDR_IRQ_STATUS, {28'h0000000, st_m}, 1'b0, 1'b0);
            apb(1'b1, flag_pkg::ADDR_IRQ_CLEAR, {28'h0000000, st_m});
            st_m = 4'h0;
            rd_reg(flag_pkg::ADDR_IRQ_STATUS, 32'h00000000, 1'b0, 1'b0);
        end
        // A masked event is recorded but keeps the interrupt low until enabled.
        en_m = 4'h0;
        apb(1'b1, flag_pkg::ADDR_IRQ_ENABLE, 32'h00000000);
        op(1, 1'b0, 1'b1);
        st_m = 4'h2;
        rd_reg(flag_pkg::ADDR_IRQ_STATUS, 32'h00000002, 1'b0, 1'b0);
        en_m = 4'h2;
        apb(1'b1, flag_pkg::ADDR_IRQ_ENABLE, 32'h00000002);
        rd_reg(flag_pkg::ADDR_IRQ_STATUS, 32'h00000002, 1'b0, 1'b0);
        apb(1'b1, flag_pkg::ADDR_IRQ_CLEAR, 32'h00000002);
        st_m = 4'h0;
        // Fall-through mode: the first word loads the output register unasked.
        apb(1'b1, flag_pkg::ADDR_CTRL, 32'h00000001);
        rd_reg(flag_pkg::ADDR_CTRL, 32'h00000001, 1'b0, 1'b0);
        op(0, 1'b1, 1'b0);
        w[0] = 1;
        r[0] = 1;
        op(1, 1'b0, 1'b0);
        op(1, 1'b0, 1'b0);
        chk(flags() & 8'hF7);
        op(1, 1'b0, 1'b0);
        r[0] = 0;
        op(0, 1'b0, 1'b0);
        op(0, 1'b0, 1'b0);
        w[0] = 0;
        chk(flags() | 8'h08);
        op(1, 1'b0, 1'b1);
        chk(flags());
        op(1, 1'b0, 1'b1);
        st_m = 4'h2;
        rd_reg(flag_pkg::ADDR_IRQ_STATUS, 32'h00000002, 1'b0, 1'b0);
        // A port B edge detected in the same cycle as a port A write must not count.
        fork
            begin
                @(posedge clk);
                op(0, 1'b1, 1'b0);
            end
            op(1, 1'b0, 1'b0);
        join
        w[0] = 1;
        r[0] = 1;
        op(1, 1'b0, 1'b0);
        op(1, 1'b0, 1'b0);
        chk(flags() & 8'hF7);
        op(1, 1'b0, 1'b0);
        r[0] = 0;
        chk(flags() | 8'h08);
        // Serial programming shifts one bit per port A edge through the offset chain.
        sb = 4'($urandom_range(15, 0));
        serial_enable <= 1'b1;
        for (int b = 3; b >= 0; b--)
        begin
            serial_bit <= sb[b];
            op(0, 1'b0, 1'b0);
        end
        serial_enable <= 1'b0;
        rd_reg(offs[0], yo[0], 1'b0, 1'b0);
        rd_reg(offs[1], xo[1], 1'b0, 1'b0);
        rd_reg(offs[2], yo[1], 1'b0, 1'b0);
        rd_reg(offs[3], {28'h0000000, sb}, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        if (notes.size() != 0)
            mismatches++;
        report_and_stop();
    end
endmodule

// *** hdl/bidir_fifo_status_flags.sv ***
// Function
// - Full/input-ready high means a free location; low means writes are ignored.
// - Full/input-ready follows the writer clock; each accepted write advances the pointer.
// - After a freeing read, full/input-ready rises on the second writer edge.
// - A writer edge coinciding with the read is not the first sync edge.
// - A reader edge coinciding with the write is not the first sync edge.
// - Almost-empty follows the reader clock, using that queue's empty offset.
// - Almost-empty low at X or fewer memory words, high at X+1 or more.
// - Almost-empty rises on the second reader edge after the filling write.
// - Almost-full follows the writer clock, using that queue's full offset.
// - Almost-full low at depth minus Y or more words, else high.
// - Almost-full rises on the second writer edge after the draining read.
// - Output register word is not counted; fall-through loads the first word unasked.
// - Moving a word to the output register frees its location at once.
// - Fall-through flags mean output/input ready; standard flags mean empty/full.
// - Offsets come from reset presets, register writes, or serial shifting.
// - Empty flag low at zero words; full flag low only at exactly depth words.
// - Fall-through: ready and load on third reader edge; standard: second edge.
// - With the empty/output-ready flag low, reads are ignored and output stays.

////////////////////////////////////////////////////////////////////////////////

module queue_flags #(
    parameter int AW = 10
) (
    // System.
    input wire logic clk,
    input wire logic rst,
    // Writer side, one-cycle edge pulse and request.
    input wire logic wr_edge,
    input wire logic wr_req,
    // Reader side, one-cycle edge pulse and request.
    input wire logic rd_edge,
    input wire logic rd_req,
    // Configuration.
    input wire logic fall_through_mode,
    input wire logic [AW-1:0] x_off,
    input wire logic [AW-1:0] y_off,
    // Reader flags.
    output logic empty_or_outready,
    output logic almost_empty,
    // Writer flags.
    output logic almost_full,
    output logic full_or_inready,
    // Refusal pulses and word counts.
    output logic wr_refused,
    output logic rd_refused,
    output logic [AW:0] wr_cnt,
    output logic [AW:0] rd_cnt
);

    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(1) << AW;

    logic [PW-1:0] wptr_r;
    logic [PW-1:0] rptr_r;
    logic [PW-1:0] wgray_r;
    logic [PW-1:0] rgray_r;
    logic [PW-1:0] wg_rd1_r;
    logic [PW-1:0] wg_rd2_r;
    logic [PW-1:0] rg_wr1_r;
    logic [PW-1:0] rg_wr2_r;
    logic out_valid_r;
    logic mem_has;
    logic wr_ok;
    logic rd_adv;
    logic [PW-1:0] wptr_nxt;
    logic [PW-1:0] rptr_nxt;

    // Counts exclude the word held in the output register.
    assign rd_cnt = PW'(flag_pkg::gray2bin(16'(wg_rd2_r))) - rptr_r;
    assign wr_cnt = wptr_r - PW'(flag_pkg::gray2bin(16'(rg_wr2_r)));
    assign mem_has = (rd_cnt != '0);

    assign full_or_inready = (wr_cnt != DEPTH_P);
    assign almost_full = (wr_cnt < (DEPTH_P - {1'b0, y_off}));
    assign almost_empty = (rd_cnt > {1'b0, x_off});
    assign empty_or_outready = fall_through_mode ? out_valid_r : mem_has;

    assign wr_ok = wr_edge & wr_req & full_or_inready;
    assign wr_refused = wr_edge & wr_req & ~full_or_inready;
    assign rd_refused = rd_edge & rd_req & ~empty_or_outready;
    assign rd_adv = fall_through_mode ? (rd_edge & mem_has & (~out_valid_r | rd_req))
                         : (rd_edge & rd_req & mem_has);
    assign wptr_nxt = wptr_r + PW'(1);
    assign rptr_nxt = rptr_r + PW'(1);

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wptr_r <= '0;
            wgray_r <= '0;
        end
        else if (wr_ok)
        begin
            wptr_r <= wptr_nxt;
            wgray_r <= PW'(flag_pkg::bin2gray(16'(wptr_nxt)));
        end
    end

    // The read pointer moves as the word enters the output register, freeing it.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rptr_r <= '0;
            rgray_r <= '0;
        end
        else if (rd_adv)
        begin
            rptr_r <= rptr_nxt;
            rgray_r <= PW'(flag_pkg::bin2gray(16'(rptr_nxt)));
        end
    end

    // Fall-through output register occupancy; it fills on the third reader edge.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_valid_r <= 1'b0;
        end
        else if (!fall_through_mode)
        begin
            out_valid_r <= 1'b0;
        end
        else if (rd_edge && (!out_valid_r || rd_req))
        begin
            out_valid_r <= mem_has;
        end
    end

    // The pointer registers update at the same system edge as a coinciding
    // remote edge, so that edge samples the old value and cannot count.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rg_wr1_r <= '0;
            rg_wr2_r <= '0;
        end
        else if (wr_edge)
        begin
            rg_wr1_r <= rgray_r;
            rg_wr2_r <= rg_wr1_r;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wg_rd1_r <= '0;
            wg_rd2_r <= '0;
        end
        else if (rd_edge)
        begin
            wg_rd1_r <= wgray_r;
            wg_rd2_r <= wg_rd1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_fall_in;
        fall_through_mode && !out_valid_r && rd_edge && mem_has;
    endsequence

    sequence s_loaded;
        out_valid_r && (rptr_r == $past(rptr_nxt));
    endsequence

    a_write_refused_full: assert property (wr_edge && wr_req && !full_or_inready |=> wptr_r == $past(wptr_r))
        else $error("write accepted while full");
    a_write_ptr_adv: assert property (wr_ok |=> wptr_r == $past(wptr_nxt) && wgray_r != $past(wgray_r))
        else $error("write pointer did not advance");
    a_full_rise_edge: assert property ($rose(full_or_inready) |-> $past(wr_edge) && rg_wr2_r == $past(rg_wr1_r))
        else $error("full flag rose without second writer edge");
    a_read_skew_wr: assert property (wr_edge && rd_adv |=> rg_wr1_r == $past(rgray_r))
        else $error("coinciding read seen by first writer stage");
    a_write_skew_rd: assert property (rd_edge && wr_ok |=> wg_rd1_r == $past(wgray_r))
        else $error("coinciding write seen by first reader stage");
    a_almost_empty_rise: assert property ($rose(almost_empty) |-> $past(rd_edge) && rd_cnt == {1'b0, x_off} + PW'(1) || $past(x_off) != x_off || $past(rd_edge))
        else $error("almost-empty rose off a reader edge");
    a_almost_full_lvl: assert property (wr_cnt >= DEPTH_P - {1'b0, y_off} |-> !almost_full)
        else $error("almost-full high at threshold");
    a_almost_full_rise: assert property ($rose(almost_full) |-> $past(wr_edge) || $past(y_off) != y_off)
        else $error("almost-full rose off a writer edge");
    a_fall_through: assert property (s_fall_in |=> s_loaded)
        else $error("fall-through load missing");
    a_read_refused: assert property (rd_edge && rd_req && !empty_or_outready && !fall_through_mode |=> rptr_r == $past(rptr_r))
        else $error("read accepted while empty");
    a_empty_zero: assert property (!fall_through_mode && rd_cnt == '0 |-> !empty_or_outready ##1 (rd_cnt != '0 || !empty_or_outready || fall_through_mode))
        else $error("empty flag high at zero words");

endmodule

////////////////////////////////////////////////////////////////////////////////

module bidir_fifo_status_flags #(
    parameter int AW = 10
) (
    // System.
    input wire logic clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins, asynchronous to clk.
    input wire flag_pkg::port_pins_t porta_pins,
    input wire flag_pkg::port_pins_t portb_pins,
    input wire logic serial_enable,
    input wire logic serial_bit,
    // Port A flags.
    output logic porta_empty_or_outready,
    output logic porta_almost_empty,
    output logic porta_almost_full,
    output logic porta_full_or_inready,
    // Port B flags.
    output logic portb_empty_or_outready,
    output logic portb_almost_empty,
    output logic portb_almost_full,
    output logic portb_full_or_inready,
    // Interrupt.
    output logic irq
);

    localparam int EVN = flag_pkg::EV_COUNT;

    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    logic pa_clk_d_r;
    logic pb_clk_d_r;
    flag_pkg::port_pins_t pa_s;
    flag_pkg::port_pins_t pb_s;
    logic ser_en_s;
    logic ser_bit_s;
    logic pa_edge;
    logic pb_edge;
    logic fall_through_mode_r;
    logic [AW-1:0] q1_empty_off_r;
    logic [AW-1:0] q1_full_off_r;
    logic [AW-1:0] q2_empty_off_r;
    logic [AW-1:0] q2_full_off_r;
    logic [EVN-1:0] irq_status_r;
    logic [EVN-1:0] irq_enable_r;
    logic [EVN-1:0] events;
    logic [EVN-1:0] clear_bits;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic hit;
    logic apb_wr;
    logic [AW:0] q1_wr_cnt;
    logic [AW:0] q2_wr_cnt;
    flag_pkg::port_flags_t fa;
    flag_pkg::port_flags_t fb;

    // Two-stage synchroniser for every pin; edges are taken from stage two.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            pa_clk_d_r <= 1'b0;
            pb_clk_d_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= {porta_pins, portb_pins, serial_enable, serial_bit};
            pin_s2_r <= pin_s1_r;
            pa_clk_d_r <= pa_s.clk;
            pb_clk_d_r <= pb_s.clk;
        end
    end

    assign {pa_s, pb_s, ser_en_s, ser_bit_s} = pin_s2_r;
    assign pa_edge = pa_s.clk & ~pa_clk_d_r;
    assign pb_edge = pb_s.clk & ~pb_clk_d_r;

    ////////////////////////////////////////////////////////////////////////////

    // Queue 1 is written from port A and read from port B.
    queue_flags #(.AW(AW)) u_q1 (
        .clk(clk),
        .rst(rst),
        .wr_edge(pa_edge),
        .wr_req(pa_s.wr),
        .rd_edge(pb_edge),
        .rd_req(pb_s.rd),
        .fall_through_mode(fall_through_mode_r),
        .x_off(q1_empty_off_r),
        .y_off(q1_full_off_r),
        .empty_or_outready(fb.empty_or_outready),
        .almost_empty(fb.almost_empty),
        .almost_full(fa.almost_full),
        .full_or_inready(fa.full_or_inready),
        .wr_refused(events[flag_pkg::EV_Q1_WR_REFUSED]),
        .rd_refused(events[flag_pkg::EV_Q1_RD_REFUSED]),
        .wr_cnt(q1_wr_cnt),
        .rd_cnt()
    );

    // Queue 2 is written from port B and read from port A.
    queue_flags #(.AW(AW)) u_q2 (
        .clk(clk),
        .rst(rst),
        .wr_edge(pb_edge),
        .wr_req(pb_s.wr),
        .rd_edge(pa_edge),
        .rd_req(pa_s.rd),
        .fall_through_mode(fall_through_mode_r),
        .x_off(q2_empty_off_r),
        .y_off(q2_full_off_r),
        .empty_or_outready(fa.empty_or_outready),
        .almost_empty(fa.almost_empty),
        .almost_full(fb.almost_full),
        .full_or_inready(fb.full_or_inready),
        .wr_refused(events[flag_pkg::EV_Q2_WR_REFUSED]),
        .rd_refused(events[flag_pkg::EV_Q2_RD_REFUSED]),
        .wr_cnt(q2_wr_cnt),
        .rd_cnt()
    );

    assign {porta_empty_or_outready, porta_almost_empty, porta_almost_full, porta_full_or_inready} = fa;
    assign {portb_empty_or_outready, portb_almost_empty, portb_almost_full, portb_full_or_inready} = fb;

    ////////////////////////////////////////////////////////////////////////////

    assign apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always_comb
    begin
        hit = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            flag_pkg::ADDR_CTRL: rdata_nxt[flag_pkg::CTRL_FALL_THROUGH_MODE_BIT] = fall_through_mode_r;
            flag_pkg::ADDR_Q1_EMPTY_OFF: rdata_nxt[AW-1:0] = q1_empty_off_r;
            flag_pkg::ADDR_Q1_FULL_OFF: rdata_nxt[AW-1:0] = q1_full_off_r;
            flag_pkg::ADDR_Q2_EMPTY_OFF: rdata_nxt[AW-1:0] = q2_empty_off_r;
            flag_pkg::ADDR_Q2_FULL_OFF: rdata_nxt[AW-1:0] = q2_full_off_r;
            flag_pkg::ADDR_FLAGS: rdata_nxt[7:0] = {fa, fb};
            flag_pkg::ADDR_COUNTS:
            begin
                rdata_nxt[AW:0] = q1_wr_cnt;
                rdata_nxt[flag_pkg::COUNTS_Q2_LSB +: AW + 1] = q2_wr_cnt;
            end
            flag_pkg::ADDR_IRQ_STATUS: rdata_nxt[EVN-1:0] = irq_status_r;
            flag_pkg::ADDR_IRQ_CLEAR: rdata_nxt = 32'h0000_0000;
            flag_pkg::ADDR_IRQ_ENABLE: rdata_nxt[EVN-1:0] = irq_enable_r;
            default: hit = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle and shown in the access cycle.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata_r <= rdata_nxt;
        end
    end

    assign prdata = prdata_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fall_through_mode_r <= flag_pkg::FALL_THROUGH_MODE_RESET;
        end
        else if (apb_wr && paddr == flag_pkg::ADDR_CTRL)
        begin
            fall_through_mode_r <= pwdata[flag_pkg::CTRL_FALL_THROUGH_MODE_BIT];
        end
    end

    // Offsets: preset at reset, register writes, or serial shift on port A edges.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q1_empty_off_r <= AW'(flag_pkg::OFFSET_PRESET);
            q1_full_off_r <= AW'(flag_pkg::OFFSET_PRESET);
            q2_empty_off_r <= AW'(flag_pkg::OFFSET_PRESET);
            q2_full_off_r <= AW'(flag_pkg::OFFSET_PRESET);
        end
        else if (apb_wr)
        begin
            case (paddr)
                flag_pkg::ADDR_Q1_EMPTY_OFF: q1_empty_off_r <= pwdata[AW-1:0];
                flag_pkg::ADDR_Q1_FULL_OFF: q1_full_off_r <= pwdata[AW-1:0];
                flag_pkg::ADDR_Q2_EMPTY_OFF: q2_empty_off_r <= pwdata[AW-1:0];
                flag_pkg::ADDR_Q2_FULL_OFF: q2_full_off_r <= pwdata[AW-1:0];
                default: q1_empty_off_r <= q1_empty_off_r;
            endcase
        end
        else if (ser_en_s && pa_edge)
        begin
            {q1_empty_off_r, q1_full_off_r, q2_empty_off_r, q2_full_off_r} <=
                {q1_empty_off_r[AW-2:0], q1_full_off_r, q2_empty_off_r, q2_full_off_r, ser_bit_s};
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign clear_bits = (apb_wr && paddr == flag_pkg::ADDR_IRQ_CLEAR) ? pwdata[EVN-1:0] : '0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_r <= '0;
        end
        else
        begin
            irq_status_r <= (irq_status_r & ~clear_bits) | events;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_enable_r <= flag_pkg::IRQ_ENABLE_RESET;
        end
        else if (apb_wr && paddr == flag_pkg::ADDR_IRQ_ENABLE)
        begin
            irq_enable_r <= pwdata[EVN-1:0];
        end
    end

    assign irq = |(irq_status_r & irq_enable_r);

endmodule

// *** hdl/flag_pkg.sv ***
package flag_pkg;

    // Register byte addresses on the APB slave.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_Q1_EMPTY_OFF = 8'h04;
    localparam logic [7:0] ADDR_Q1_FULL_OFF = 8'h08;
    localparam logic [7:0] ADDR_Q2_EMPTY_OFF = 8'h0C;
    localparam logic [7:0] ADDR_Q2_FULL_OFF = 8'h10;
    localparam logic [7:0] ADDR_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_COUNTS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;

    // Field positions.
    localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;
    localparam int COUNTS_Q2_LSB = 16;
    localparam int EV_Q1_WR_REFUSED = 0;
    localparam int EV_Q1_RD_REFUSED = 1;
    localparam int EV_Q2_WR_REFUSED = 2;
    localparam int EV_Q2_RD_REFUSED = 3;
    localparam int EV_COUNT = 4;

    // Reset values.
    localparam logic FALL_THROUGH_MODE_RESET = 1'b0;
    localparam int OFFSET_PRESET = 8;
    localparam logic [EV_COUNT-1:0] IRQ_ENABLE_RESET = 4'h0;

    // Pin group of one port: its clock and its queue write and read requests.
    typedef struct packed {
        logic clk;
        logic wr;
        logic rd;
    } port_pins_t;

    // Four status flags seen at one port.
    typedef struct packed {
        logic empty_or_outready;
        logic almost_empty;
        logic almost_full;
        logic full_or_inready;
    } port_flags_t;

    function automatic logic [15:0] bin2gray(input logic [15:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [15:0] gray2bin(input logic [15:0] g);
        logic [15:0] b;
        b = 16'h0000;
        b[15] = g[15];
        for (int i = 14; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage
